//--- logic/stepper_position_sequencer.sv
// Overview of operation
// R1 - target below position: keep stepping in reverse until both are equal
// R2 - reverse group drives 0a,06,05,09,00 with delays, then position minus one
// R3 - reverse groups repeat position minus target times, one position each
// R4 - remember last phase and continue sequence from it, never breaking order
// R5 - after a move, clear measurement and loop compare, hold, move, measure
// R6 - alternate mapping outputs 0a,28,24,06 instead of 0a,09,05,06
// R7 - target above position: drive 0a,09,05,06,00 with delays, position plus one
// R8 - measure period and high time; target is high times 100 over period
// R9 - at start step reverse 100 times to the stop, then position zero
// R10 - equal positions: hold for 5000 counts before measuring again
// R11 - step delay is a programmable cycle count loaded at each new pattern
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module stepper_position_sequencer #(
  parameter int IDLE_CYCLES = stepper_pkg::IDLE_COUNT,
  parameter int CNT_W       = 16
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pwm input
  input  wire logic        pwm_in,
  // coil drivers
  output logic      [7:0]  coil_port_data
);

  if (IDLE_CYCLES < 1 || IDLE_CYCLES > 65535)
  begin : g_bad_idle
    $error("stepper_position_sequencer: IDLE_CYCLES out of range");
  end

  localparam int          PW       = stepper_pkg::POS_W;
  localparam logic [15:0] IDLE_LD  = 16'(IDLE_CYCLES - 1);

  typedef struct packed {
    stepper_pkg::seq_state_e state;
    logic [7:0]              coil;
    logic [1:0]              phase;
    logic [2:0]              sub;
    logic [15:0]             step_delay_wait;
    logic [15:0]             idle_cnt;
    logic [PW-1:0]           present;
    logic [PW-1:0]           target;
    logic [7:0]              init_cnt;
    logic                    meas_ok;
    logic                    meas_start;
    logic                    run;
    logic                    alt;
    logic [15:0]             step_delay;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } seq_s;

  seq_s               r_reg;
  seq_s               r_next;
  stepper_pkg::meas_s meas;
  logic               moving;
  logic               dir_rev;
  logic [1:0]         phase_step;
  logic [15:0]        delay_ld;
  logic [PW-1:0]      pos_after;
  logic               apb_access;

  // ==========================================================
  // duty measurement
  duty_meter #(
    .CNT_W (CNT_W)
  ) u_meter (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .start   (r_reg.meas_start),
    .pwm_in  (pwm_in),
    .meas    (meas)
  );

  assign moving     = (r_reg.state == stepper_pkg::ST_INIT) ||
                      (r_reg.state == stepper_pkg::ST_FWD) ||
                      (r_reg.state == stepper_pkg::ST_REV);
  assign dir_rev    = (r_reg.state != stepper_pkg::ST_FWD);
  // R4 next phase taken from the stored one
  assign phase_step = dir_rev ? r_reg.phase - 2'h1 : r_reg.phase + 2'h1;
  // a zero delay would stall nothing; treat as one cycle
  assign delay_ld   = (r_reg.step_delay == 16'h0000) ? 16'h0000 : r_reg.step_delay - 16'h0001;
  assign pos_after  = (r_reg.state == stepper_pkg::ST_FWD) ? r_reg.present + 1'b1
                                                           : r_reg.present - 1'b1;
  assign apb_access = psel && penable && !r_reg.pready;

  // ==========================================================
  // next state
  always_comb
  begin
    r_next = r_reg;
    r_next.meas_start = 1'b0;
    r_next.pready     = 1'b0;
    r_next.pslverr    = 1'b0;

    // one wait state: answer in the cycle after the first access cycle
    if (apb_access)
    begin
      r_next.pready = 1'b1;
      r_next.prdata = 32'h0000_0000;
      case (paddr)
        stepper_pkg::CTRL_OFF:
        begin
          r_next.prdata = {30'h0, r_reg.alt, r_reg.run};
          if (pwrite)
          begin
            r_next.run = pwdata[stepper_pkg::CTRL_RUN_BIT];
            r_next.alt = pwdata[stepper_pkg::CTRL_ALT_BIT];
          end
        end
        // R11 programmable step delay
        stepper_pkg::DELAY_OFF:
        begin
          r_next.prdata = {16'h0, r_reg.step_delay};
          if (pwrite)
            r_next.step_delay = pwdata[15:0];
        end
        stepper_pkg::STATUS_OFF:
          r_next.prdata = {28'h0, r_reg.meas_ok, r_reg.state};
        stepper_pkg::POS_OFF:
          r_next.prdata = {16'h0, r_reg.target, r_reg.present};
        stepper_pkg::COIL_OFF:
          r_next.prdata = {24'h0, r_reg.coil};
        default:
          r_next.pslverr = 1'b1;
      endcase
    end

    // R11 pattern stands until the down-counter runs out
    if (moving && r_reg.step_delay_wait != 16'h0000)
      r_next.step_delay_wait = r_reg.step_delay_wait - 16'h0001;
    else
    begin
      case (r_reg.state)
        stepper_pkg::ST_INIT, stepper_pkg::ST_FWD, stepper_pkg::ST_REV:
        begin
          // R2 R7 four phase patterns, then coils off
          if (r_reg.sub < 3'h4)
          begin
            r_next.phase           = phase_step;
            // R6 alternate mapping in the pattern lookup
            r_next.coil            = stepper_pkg::phase_pattern(phase_step, r_reg.alt);
            r_next.sub             = r_reg.sub + 3'h1;
            r_next.step_delay_wait = delay_ld;
          end
          else if (r_reg.sub == 3'h4)
          begin
            r_next.coil            = stepper_pkg::COIL_OFF_PAT;
            r_next.sub             = 3'h5;
            r_next.step_delay_wait = delay_ld;
          end
          else
          begin
            r_next.sub = 3'h0;
            if (r_reg.state == stepper_pkg::ST_INIT)
            begin
              // R9 hundred reverse groups, then origin
              r_next.init_cnt = r_reg.init_cnt - 8'h01;
              if (r_reg.init_cnt == 8'h01)
              begin
                r_next.present    = stepper_pkg::START_POS;
                r_next.state      = stepper_pkg::ST_MEASURE;
                r_next.meas_start = 1'b1;
              end
            end
            else
            begin
              // R1 R3 one position per group until equal
              r_next.present = pos_after;
              if (pos_after == r_reg.target)
              begin
                // R5 stale measurement, start over
                r_next.meas_ok    = 1'b0;
                r_next.state      = stepper_pkg::ST_MEASURE;
                r_next.meas_start = 1'b1;
              end
            end
          end
        end
        stepper_pkg::ST_MEASURE:
          if (meas.valid)
          begin
            r_next.target  = meas.target;
            r_next.meas_ok = 1'b1;
            r_next.state   = stepper_pkg::ST_COMPARE;
          end
        stepper_pkg::ST_COMPARE:
          // clearing run parks the loop here between moves
          if (r_reg.run)
          begin
            if (r_reg.target == r_reg.present)
            begin
              r_next.state    = stepper_pkg::ST_HOLD;
              r_next.idle_cnt = IDLE_LD;
            end
            else if (r_reg.target > r_reg.present)
              r_next.state = stepper_pkg::ST_FWD;
            else
              r_next.state = stepper_pkg::ST_REV;
          end
        // R10 hold before measuring again
        stepper_pkg::ST_HOLD:
          if (r_reg.idle_cnt == 16'h0000)
          begin
            r_next.meas_ok    = 1'b0;
            r_next.state      = stepper_pkg::ST_MEASURE;
            r_next.meas_start = 1'b1;
          end
          else
            r_next.idle_cnt = r_reg.idle_cnt - 16'h0001;
        default:
          r_next.state = stepper_pkg::ST_COMPARE;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg            <= '0;
      r_reg.state      <= stepper_pkg::ST_INIT;
      r_reg.phase      <= stepper_pkg::PHASE_RESET;
      r_reg.init_cnt   <= stepper_pkg::SWITCH_ON;
      r_reg.run        <= stepper_pkg::CTRL_RESET[0];
      r_reg.alt        <= stepper_pkg::CTRL_RESET[1];
      r_reg.step_delay <= stepper_pkg::STEP_DELAY_CYC;
    end
    else
      r_reg <= r_next;
  end

  assign coil_port_data = r_reg.coil;
  assign prdata         = r_reg.prdata;
  assign pready         = r_reg.pready;
  assign pslverr        = r_reg.pslverr;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [15:0] hold_run;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      hold_run <= 16'h0000;
    else if (r_reg.state == stepper_pkg::ST_HOLD)
      hold_run <= hold_run + 16'h0001;
    else
      hold_run <= 16'h0000;
  end

  sequence group_end_s;
    moving && r_reg.sub == 3'h5 && r_reg.step_delay_wait == 16'h0000;
  endsequence

  sequence rev_done_s;
    group_end_s ##0 r_reg.state == stepper_pkg::ST_REV;
  endsequence

  // R2 reverse group lowers position by one
  rev_step_a: assert property (rev_done_s |=> r_reg.present == $past(r_reg.present) - 1'b1) // R2
    else $error("reverse group did not decrement position");

  // R7 forward group raises position by one
  fwd_step_a: assert property (group_end_s ##0 r_reg.state == stepper_pkg::ST_FWD
    |=> r_reg.present == $past(r_reg.present) + 1'b1) // R7
    else $error("forward group did not increment position");

  // R1 compare with lower target goes reverse
  rev_choice_a: assert property (r_reg.state == stepper_pkg::ST_COMPARE && r_reg.run &&
    r_reg.target < r_reg.present |=> r_reg.state == stepper_pkg::ST_REV) // R1
    else $error("lower target did not start reverse move");

  // R3 no overshoot past the target in reverse
  rev_bound_a: assert property (r_reg.state == stepper_pkg::ST_REV |->
    r_reg.present > r_reg.target) // R3
    else $error("reverse move past target");

  // R4 each new pattern is one phase from the last
  phase_order_a: assert property (moving && r_reg.sub < 3'h4 && r_reg.step_delay_wait == 16'h0000
    |=> (r_reg.phase == $past(r_reg.phase) + 2'h1) ||
        (r_reg.phase == $past(r_reg.phase) - 2'h1)) // R4
    else $error("phase order broken");

  // R5 end of a reverse move drops the measurement and remeasures
  loop_back_a: assert property (rev_done_s ##0 pos_after == r_reg.target
    |=> r_reg.state == stepper_pkg::ST_MEASURE && !r_reg.meas_ok && r_reg.meas_start) // R5
    else $error("move end did not return to measurement");

  // R6 alternate mapping patterns only
  // pattern was looked up with the mapping of the cycle before
  alt_map_a: assert property ($past(r_reg.alt) && coil_port_data != 8'h00 && $changed(coil_port_data)
    |-> coil_port_data inside {8'h0a, 8'h28, 8'h24, 8'h06}) // R6
    else $error("illegal pattern in alternate mapping");

  // R9 origin set after the homing run
  home_zero_a: assert property (r_reg.state == stepper_pkg::ST_INIT ##1
    r_reg.state == stepper_pkg::ST_MEASURE |-> r_reg.present == 8'h00 && r_reg.init_cnt == 8'h00) // R9
    else $error("homing did not end at origin");

  // R10 hold lasts the full idle count
  hold_len_a: assert property ($fell(r_reg.state == stepper_pkg::ST_HOLD)
    |-> hold_run == 16'(IDLE_CYCLES)) // R10
    else $error("hold length wrong");

  // R11 a fresh pattern stands at least two cycles when the programmed delay is two or more
  delay_hold_a: assert property ($changed(coil_port_data) && r_reg.step_delay >= 16'h0002
    |=> $stable(coil_port_data)) // R11
    else $error("pattern changed before step delay");

endmodule // stepper_position_sequencer

//--- shared/stepper_pkg.sv
package stepper_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] DELAY_OFF  = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] POS_OFF    = 8'h0c;
  localparam logic [7:0] COIL_OFF   = 8'h10;

  // ==========================================================
  // control fields and reset values
  localparam int         CTRL_RUN_BIT  = 0;
  localparam int         CTRL_ALT_BIT  = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h1;
  localparam int         STAT_VALID_BIT = 3;

  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          STEP_DELAY_NS  = 1000;
  localparam logic [15:0] STEP_DELAY_CYC = 16'((STEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          IDLE_COUNT     = 5000;

  // ==========================================================
  // positions and patterns
  localparam int          POS_W        = 8;
  localparam logic [7:0]  SWITCH_ON    = 8'h64;
  localparam logic [7:0]  START_POS    = 8'h00;
  localparam logic [7:0]  PCT_SCALE    = 8'h64;
  localparam logic [7:0]  COIL_OFF_PAT = 8'h00;
  localparam logic [1:0]  PHASE_RESET  = 2'h1;

  typedef enum logic [2:0] {ST_INIT, ST_MEASURE, ST_COMPARE, ST_HOLD, ST_FWD, ST_REV} seq_state_e;
  typedef enum logic [2:0] {M_IDLE, M_RISE1, M_PERIOD, M_HIGH, M_DIV} meter_state_e;

  typedef struct packed {
    logic             valid;
    logic [POS_W-1:0] target;
  } meas_s;

  // phase 0..3 in forward order; alt selects the remapped port bits
  function automatic logic [7:0] phase_pattern(input logic [1:0] phase, input logic alt);
    logic [7:0] p;
    p = 8'h00;
    case (phase)
      2'h0: p = 8'h0a;
      2'h1: p = alt ? 8'h28 : 8'h09;
      2'h2: p = alt ? 8'h24 : 8'h05;
      default: p = 8'h06;
    endcase
    return p;
  endfunction

endpackage

//--- logic/duty_meter.sv
`timescale 1ns/1ns
module duty_meter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // control
  input  wire logic               start,
  input  wire logic               pwm_in,
  // result
  output stepper_pkg::meas_s      meas
);

  localparam int NUM_W = CNT_W + 7;

  if (CNT_W < 8 || CNT_W > 24)
  begin : g_bad_width
    $error("duty_meter: CNT_W out of range");
  end

  typedef struct packed {
    stepper_pkg::meter_state_e st;
    logic                      pwm_d;
    logic [CNT_W-1:0]          cnt;
    logic [CNT_W-1:0]          period;
    logic [NUM_W-1:0]          num;
    logic [NUM_W-1:0]          quo;
    logic [CNT_W:0]            rem;
    logic [4:0]                bits;
    stepper_pkg::meas_s        res;
  } meter_s;

  meter_s r_reg;
  meter_s r_next;
  logic   rise;
  logic   fall;
  logic [CNT_W:0] rem_s;

  assign rise = pwm_in & ~r_reg.pwm_d;
  assign fall = ~pwm_in & r_reg.pwm_d;
  assign rem_s = {r_reg.rem[CNT_W-1:0], r_reg.num[NUM_W-1]};

  // ==========================================================
  // capture and divide
  always_comb
  begin
    r_next = r_reg;
    r_next.pwm_d = pwm_in;
    r_next.res.valid = 1'b0;
    if (r_reg.cnt != '1)
      r_next.cnt = r_reg.cnt + 1'b1;
    case (r_reg.st)
      stepper_pkg::M_IDLE:
        if (start)
          r_next.st = stepper_pkg::M_RISE1;
      stepper_pkg::M_RISE1:
        if (rise)
        begin
          // the edge cycle is the first counted cycle, else period and high read one short
          r_next.cnt = CNT_W'(1);
          r_next.st  = stepper_pkg::M_PERIOD;
        end
      // R8 period then high time
      stepper_pkg::M_PERIOD:
        if (rise)
        begin
          r_next.period = r_reg.cnt;
          r_next.cnt    = CNT_W'(1);
          r_next.st     = stepper_pkg::M_HIGH;
        end
      stepper_pkg::M_HIGH:
        if (fall)
        begin
          r_next.num  = NUM_W'(r_reg.cnt) * NUM_W'(stepper_pkg::PCT_SCALE);
          r_next.rem  = '0;
          r_next.quo  = '0;
          r_next.bits = 5'(NUM_W);
          r_next.st   = stepper_pkg::M_DIV;
        end
      // R8 scale by 100 over period, restoring division
      stepper_pkg::M_DIV:
        if (r_reg.bits == 5'h00)
        begin
          r_next.res.valid = 1'b1;
          if (r_reg.period == '0)
            r_next.res.target = '0;
          else if (r_reg.quo > NUM_W'(stepper_pkg::PCT_SCALE))
            r_next.res.target = stepper_pkg::PCT_SCALE;
          else
            r_next.res.target = r_reg.quo[stepper_pkg::POS_W-1:0];
          r_next.st = stepper_pkg::M_IDLE;
        end
        else
        begin
          r_next.bits = r_reg.bits - 5'h01;
          r_next.num  = {r_reg.num[NUM_W-2:0], 1'b0};
          if (rem_s >= {1'b0, r_reg.period})
          begin
            r_next.rem = rem_s - {1'b0, r_reg.period};
            r_next.quo = {r_reg.quo[NUM_W-2:0], 1'b1};
          end
          else
          begin
            r_next.rem = rem_s;
            r_next.quo = {r_reg.quo[NUM_W-2:0], 1'b0};
          end
        end
      default:
        r_next.st = stepper_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign meas = r_reg.res;

  // R8 result never beyond full scale
  target_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    meas.valid |-> meas.target <= stepper_pkg::PCT_SCALE) // R8
    else $error("measured target above full scale");

endmodule // duty_meter

//--- sim/pwm_motor_model.sv
`timescale 1ns/1ns
module pwm_motor_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // pwm source
  input  wire logic [15:0] period,
  input  wire logic [15:0] high,
  output logic             pwm_in,
  // coil side
  input  wire logic [7:0]  coil,
  output int               steps,
  output int               bad,
  output int               alt_cnt,
  output int               std_cnt,
  output int               last_run
);
  logic [15:0] cnt;
  logic [7:0]  prev;
  int          ph;
  int          run;
  int          k;

  function automatic int phase_of(input logic [7:0] p);
    case (p)
      8'h0a:        return 0;
      8'h09, 8'h28: return 1;
      8'h05, 8'h24: return 2;
      8'h06:        return 3;
      default:      return -1;
    endcase
  endfunction

  // ==========================================================
  // pwm source and rotor model
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 16'h0000; pwm_in <= 1'b0; prev <= 8'h00; ph <= 1; run <= 0;
      steps <= 0; bad <= 0; alt_cnt <= 0; std_cnt <= 0; last_run <= 0;
    end
    else
    begin
      // period change applies at once; a count already at or past the new period wraps on the next cycle
      cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      pwm_in <= (cnt < high);
      run <= (coil == prev) ? run + 1 : 1;
      prev <= coil;
      if (coil != prev && prev != 8'h00)
        last_run <= run;
      if (coil != prev && coil != 8'h00)
      begin
        k = phase_of(coil);
        if (coil == 8'h28 || coil == 8'h24)
          alt_cnt <= alt_cnt + 1;
        if (coil == 8'h09 || coil == 8'h05)
          std_cnt <= std_cnt + 1;
        if (k < 0)
          bad <= bad + 1;
        else if (k == (ph + 1) % 4)
          steps <= steps + 1;
        else if (k == (ph + 3) % 4)
          steps <= steps - 1;
        else
          bad <= bad + 1;
        if (k >= 0)
          ph <= k;
      end
    end
  end
endmodule // pwm_motor_model

//--- sim/tb_stepper_position_sequencer.sv
`timescale 1ns/1ns
module tb_stepper_position_sequencer;
  // ==========================================================
  // signals
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm_in;
  logic [7:0]  coil_port_data;
  logic [15:0] period  = 16'h0064;
  logic [15:0] high    = 16'h001e;
  int          steps, bad, alt_cnt, std_cnt, last_run;
  int          num_errors = 0;
  int          compares   = 0;
  int          cycles     = 0;
  logic [31:0] rd;
  logic        er;

  always #20 ref_clk = ~ref_clk;

  stepper_position_sequencer #(.IDLE_CYCLES(20), .CNT_W(16)) i_stepper_position_sequencer (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_in(pwm_in), .coil_port_data(coil_port_data));

  pwm_motor_model i_pwm_motor_model (
    .ref_clk(ref_clk), .resetn(resetn), .period(period), .high(high), .pwm_in(pwm_in),
    .coil(coil_port_data), .steps(steps), .bad(bad), .alt_cnt(alt_cnt),
    .std_cnt(std_cnt), .last_run(last_run));

  // ==========================================================
  // helpers
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never answers
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] exp_target(input int h, input int p);
    int t;
    t = (h * 100) / p;
    return (t > 100) ? 8'h64 : 8'(t);
  endfunction

  task automatic arrive(input logic [7:0] t);
    int         n;
    logic [7:0] st;
    for (n = 0; n < 3000; n++)
    begin
      apb(1'b0, stepper_pkg::STATUS_OFF, 32'h0);
      st = rd[7:0];
      apb(1'b0, stepper_pkg::POS_OFF, 32'h0);
      if (st[2:0] == 3'h3 && rd[7:0] == t && rd[15:8] == t)
        break;
    end
    check({16'h0, rd[15:0]}, {16'h0, t, t}, "target and position");
    check({28'h0, st[3:0]}, 32'hb, "hold state");
  endtask

  // ==========================================================
  // timeout
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      num_errors++;
      $display("Error at %0t: run took too long", $time);
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [15:0] cp [4];
    logic [15:0] ch [4];
    logic [15:0] p, h;
    logic [7:0]  tgt, old;
    logic        alt;
    logic [31:0] dly;
    int          s0, n0, a0, i;
    cp = '{16'h0064, 16'h0064, 16'h0064, 16'h0064};
    ch = '{16'h0063, 16'h0001, 16'h0001, 16'h0032};
    void'($urandom(95));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, stepper_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'h1, "ctrl reset");
    apb(1'b0, stepper_pkg::DELAY_OFF, 32'h0);
    check(rd, 32'(stepper_pkg::STEP_DELAY_CYC), "delay reset");
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, stepper_pkg::DELAY_OFF, 32'h1);
    $display("test registers done");
    for (i = 0; i < 3000; i++)
    begin
      apb(1'b0, stepper_pkg::STATUS_OFF, 32'h0);
      if (rd[2:0] != 3'h0)
        break;
    end
    apb(1'b0, stepper_pkg::POS_OFF, 32'h0);
    check({24'h0, rd[7:0]}, 32'h0, "home position");
    check(steps, -400, "homing steps");
    check(last_run, 1, "pattern stand");
    $display("test homing done");
    old = 8'h00;
    for (i = 0; i < 9; i++)
    begin
      if (i < 4)
      begin
        p = cp[i];
        h = ch[i];
      end
      else
      begin
        p = 16'($urandom_range(150, 40));
        h = 16'($urandom_range(p - 1, 1));
      end
      alt = 1'($urandom_range(1, 0));
      dly = $urandom_range(3, 1);
      apb(1'b1, stepper_pkg::CTRL_OFF, {30'h0, alt, 1'b1});
      apb(1'b1, stepper_pkg::DELAY_OFF, dly);
      apb(1'b0, stepper_pkg::DELAY_OFF, 32'h0);
      check(rd, dly, "delay readback");
      s0 = steps;
      n0 = std_cnt;
      a0 = alt_cnt;
      period <= p;
      high <= h;
      tgt = exp_target(h, p);
      arrive(tgt);
      check(steps - s0, 4 * (int'(tgt) - int'(old)), "net steps");
      check(bad, 0, "phase order");
      if (tgt != old)
        check(last_run, dly, "pattern stand");
      if (alt && tgt != old)
        check(std_cnt - n0, 0, "plain map used");
      if (alt && tgt != old)
        check(alt_cnt > a0, 1, "alternate map used");
      old = tgt;
      $display("test move %0d done", i);
    end
    conclude();
  end
endmodule // tb_stepper_position_sequencer
